// [core/adccfg_regs.sv]
// Converter configuration registers with APB slave and conversion timer
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module adccfg_regs #(
  parameter int unsigned CLK_HZ = adccfg_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic conv_start,
  input wire logic [15:0] conv_data,
  // Configuration outputs
  output logic [2:0] rate_select,
  output logic turbo_speed,
  output logic modulator_clk,
  output logic continuous_conversion_select,
  output logic conversion_busy,
  output logic [1:0] ref_source,
  output logic temp_sensor_enable,
  output logic mux_gain_bypass,
  output logic sample_counter_enable,
  output logic [1:0] integrity_mode,
  output logic burnout_source_enable,
  output logic [2:0] excitation_source_one,
  output logic [2:0] excitation_source_two,
  // Status
  output logic result_ready_flag,
  output logic irq
);

  localparam int unsigned CW = adccfg_pkg::CNT_W;
  localparam int unsigned MOD_HALF_NORMAL =
    CLK_HZ / (2 * adccfg_pkg::MOD_HZ_NORMAL);
  localparam int unsigned MOD_HALF_TURBO =
    CLK_HZ / (2 * adccfg_pkg::MOD_HZ_TURBO);

  logic [7:0] timing_ff;
  logic [6:0] check_exc_ff;
  logic ready_ff;
  logic [15:0] data_ff;
  logic [15:0] check_ff;
  logic [7:0] scnt_ff;
  logic [1:0] stat_ff;
  logic [1:0] nxt_stat;
  logic [1:0] en_ff;
  logic irq_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_mux;
  logic [1:0] ref_ff;
  logic bypass_ff;
  logic mod_clk_ff;
  adccfg_pkg::adccfg_conv_e state_ff;
  logic [9:0] idx;
  logic mapped;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_data_clr;
  logic conv_done;
  logic mod_tick;
  logic rate_ok;
  logic [CW-1:0] conv_period;
  logic [CW-1:0] mod_half;
  logic [1:0] ev;
  logic [1:0] clr;

  // ***********************************************
  // APB decode
  // ***********************************************
  assign idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (idx >= adccfg_pkg::IDX_TIMING) &&
                  (idx <= adccfg_pkg::IDX_CHECK_WORD);
  assign setup = psel && !penable;
  assign access = psel && penable && pready_ff;
  assign wr_en = access && pwrite && mapped && pstrb[0];
  assign rd_data_clr = access && !pwrite && mapped &&
                       (idx == adccfg_pkg::IDX_DATA);

  always_comb begin
    rd_mux = '0;
    case (idx)
      adccfg_pkg::IDX_TIMING: rd_mux[7:0] = timing_ff;
      adccfg_pkg::IDX_CHECK_EXC: rd_mux[7:0] = {ready_ff, check_exc_ff};
      adccfg_pkg::IDX_DATA: rd_mux = {8'h00, scnt_ff, data_ff};
      adccfg_pkg::IDX_IRQ_STAT: rd_mux[1:0] = stat_ff;
      adccfg_pkg::IDX_IRQ_EN: rd_mux[1:0] = en_ff;
      adccfg_pkg::IDX_CHECK_WORD: rd_mux[15:0] = check_ff;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup && !pwrite && mapped) begin
        prdata_ff <= rd_mux;
      end else if (setup) begin
        prdata_ff <= '0;
      end
    end
  end

  // ***********************************************
  // Configuration registers
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_ff <= adccfg_pkg::TIMING_RST;
    end else if (wr_en && idx == adccfg_pkg::IDX_TIMING) begin
      timing_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_exc_ff <= adccfg_pkg::CHECK_EXC_RST;
    end else if (wr_en && idx == adccfg_pkg::IDX_CHECK_EXC) begin
      check_exc_ff <= pwdata[6:0];
    end
  end

  // Effective reference and input routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ff <= adccfg_pkg::REF_INTERNAL;
      bypass_ff <= 1'b0;
    end else begin
      bypass_ff <= timing_ff[adccfg_pkg::TEMP_BIT];
      if (timing_ff[adccfg_pkg::TEMP_BIT]) begin
        ref_ff <= adccfg_pkg::REF_INTERNAL;
      end else if (timing_ff[adccfg_pkg::REF_HI]) begin
        ref_ff <= adccfg_pkg::REF_SUPPLY;
      end else begin
        ref_ff <= timing_ff[adccfg_pkg::REF_HI:adccfg_pkg::REF_LO];
      end
    end
  end

  // ***********************************************
  // Modulator clock
  // ***********************************************
  assign mod_half = timing_ff[adccfg_pkg::SPEED_BIT] ?
    CW'(MOD_HALF_TURBO) : CW'(MOD_HALF_NORMAL);

  adccfg_divider #(.CW(CW)) u_mod_div (
    .clk(pclk),
    .rst_n(presetn),
    .run(1'b1),
    .period(mod_half),
    .tick(mod_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_clk_ff <= 1'b0;
    end else if (mod_tick) begin
      mod_clk_ff <= !mod_clk_ff;
    end
  end

  // ***********************************************
  // Conversion timing
  // ***********************************************
  assign rate_ok = rate_select != adccfg_pkg::RATE_RESERVED;

  always_comb begin
    conv_period = '1;
    case (timing_ff[adccfg_pkg::RATE_HI:adccfg_pkg::RATE_LO])
      3'h0: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_0);
      3'h1: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_1);
      3'h2: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_2);
      3'h3: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_3);
      3'h4: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_4);
      3'h5: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_5);
      3'h6: conv_period = CW'(CLK_HZ / adccfg_pkg::SPS_6);
      default: conv_period = '1;
    endcase
    if (timing_ff[adccfg_pkg::SPEED_BIT]) begin
      conv_period = conv_period >> 1;
    end
  end

  adccfg_divider #(.CW(CW)) u_conv_div (
    .clk(pclk),
    .rst_n(presetn),
    .run(state_ff == adccfg_pkg::ADCCFG_RUN),
    .period(conv_period),
    .tick(conv_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= adccfg_pkg::ADCCFG_IDLE;
    end else begin
      case (state_ff)
        adccfg_pkg::ADCCFG_IDLE: begin
          if (rate_ok && (continuous_conversion_select || conv_start)) begin
            state_ff <= adccfg_pkg::ADCCFG_RUN;
          end
        end
        adccfg_pkg::ADCCFG_RUN: begin
          if (!rate_ok) begin
            state_ff <= adccfg_pkg::ADCCFG_IDLE;
          end else if (conv_done && !continuous_conversion_select) begin
            state_ff <= adccfg_pkg::ADCCFG_IDLE;
          end
        end
        default: state_ff <= adccfg_pkg::ADCCFG_IDLE;
      endcase
    end
  end

  // ***********************************************
  // Result capture, counter and integrity word
  // ***********************************************
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    logic fb;
    c = adccfg_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ adccfg_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= '0;
      check_ff <= '0;
    end else if (conv_done) begin
      data_ff <= conv_data;
      case (integrity_mode)
        adccfg_pkg::CHK_INVERT: check_ff <= ~conv_data;
        adccfg_pkg::CHK_CRC: check_ff <= crc16(conv_data);
        default: check_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt_ff <= '0;
    end else if (!sample_counter_enable) begin
      scnt_ff <= '0;
    end else if (conv_done) begin
      scnt_ff <= scnt_ff + 8'h01;
    end
  end

  // Ready flag: a new result wins over a same-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
    end else if (conv_done) begin
      ready_ff <= 1'b1;
    end else if (rd_data_clr) begin
      ready_ff <= 1'b0;
    end
  end

  // ***********************************************
  // Interrupts
  // ***********************************************
  assign ev[adccfg_pkg::IRQ_READY] = conv_done;
  assign ev[adccfg_pkg::IRQ_OVERRUN] = conv_done && ready_ff && !rd_data_clr;
  assign clr = (wr_en && idx == adccfg_pkg::IDX_IRQ_CLR) ? pwdata[1:0] : '0;
  assign nxt_stat = ev | (stat_ff & ~clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= '0;
      en_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & en_ff);
      if (wr_en && idx == adccfg_pkg::IDX_IRQ_EN) begin
        en_ff <= pwdata[1:0];
      end
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rate_select = timing_ff[adccfg_pkg::RATE_HI:adccfg_pkg::RATE_LO];
  assign turbo_speed = timing_ff[adccfg_pkg::SPEED_BIT];
  assign modulator_clk = mod_clk_ff;
  assign continuous_conversion_select = timing_ff[adccfg_pkg::CONT_BIT];
  assign conversion_busy = state_ff == adccfg_pkg::ADCCFG_RUN;
  assign ref_source = ref_ff;
  assign temp_sensor_enable = timing_ff[adccfg_pkg::TEMP_BIT];
  assign mux_gain_bypass = bypass_ff;
  assign sample_counter_enable = check_exc_ff[adccfg_pkg::CNTEN_BIT];
  assign integrity_mode = check_exc_ff[adccfg_pkg::CHK_HI:adccfg_pkg::CHK_LO];
  assign burnout_source_enable = check_exc_ff[adccfg_pkg::BURN_BIT];
  assign excitation_source_one =
    check_exc_ff[adccfg_pkg::EXC_HI:adccfg_pkg::EXC_LO];
  assign excitation_source_two =
    check_exc_ff[adccfg_pkg::EXC_HI:adccfg_pkg::EXC_LO];
  assign result_ready_flag = ready_ff;
  assign irq = irq_ff;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rate_reserved;
    (rate_select == adccfg_pkg::RATE_RESERVED) |=>
      (state_ff == adccfg_pkg::ADCCFG_IDLE);
  endproperty
  a_rate_reserved: assert property (p_rate_reserved)
    else $error("Conversion runs on reserved rate code");

  property p_turbo_half;
    (turbo_speed && rate_select == 3'h0) |->
      conv_period == CW'(CLK_HZ / (adccfg_pkg::SPS_0 * 2));
  endproperty
  a_turbo_half: assert property (p_turbo_half)
    else $error("Turbo period not half of normal");

  property p_mod_speed;
    mod_tick |=> (modulator_clk != $past(modulator_clk)) &&
      (mod_half == (turbo_speed ? CW'(MOD_HALF_TURBO) :
                    CW'(MOD_HALF_NORMAL)));
  endproperty
  a_mod_speed: assert property (p_mod_speed)
    else $error("Modulator clock divider wrong");

  property p_single_stop;
    (conversion_busy && conv_done && !continuous_conversion_select
     && rate_ok) |=> !conversion_busy;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("Single-shot did not stop after result");

  property p_ref_supply;
    (!temp_sensor_enable && timing_ff[adccfg_pkg::REF_HI]) |=>
      ref_source == adccfg_pkg::REF_SUPPLY;
  endproperty
  a_ref_supply: assert property (p_ref_supply)
    else $error("Supply reference not selected");

  property p_temp_override;
    temp_sensor_enable && $stable(temp_sensor_enable) |=>
      (ref_source == adccfg_pkg::REF_INTERNAL) && mux_gain_bypass;
  endproperty
  a_temp_override: assert property (p_temp_override)
    else $error("Temp sensor did not force internal reference");

  property p_ready_set;
    conv_done |=> result_ready_flag ##0 stat_ff[adccfg_pkg::IRQ_READY];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("Ready flag not set by new result");

  property p_ready_clr;
    (rd_data_clr && !conv_done) |=> !result_ready_flag;
  endproperty
  a_ready_clr: assert property (p_ready_clr)
    else $error("Ready flag not cleared by data read");

  property p_counter_off;
    !sample_counter_enable |=> scnt_ff == 8'h00;
  endproperty
  a_counter_off: assert property (p_counter_off)
    else $error("Sample counter runs while disabled");

  property p_invert_copy;
    (conv_done && integrity_mode == adccfg_pkg::CHK_INVERT) |=>
      check_ff == ~data_ff;
  endproperty
  a_invert_copy: assert property (p_invert_copy)
    else $error("Inverted copy wrong");

  c_continuous: cover property (continuous_conversion_select &&
    conv_done ##1 conversion_busy);
  c_single: cover property (conv_start ##[1:1000] conv_done);
  c_read_clear: cover property (result_ready_flag && rd_data_clr);

endmodule

// [core/adccfg_pkg.sv]
// Constants for the converter configuration register block
package adccfg_pkg;

  // ***********************************************
  // Clock and timing
  // ***********************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned MOD_HZ_NORMAL = 256_000;
  localparam int unsigned MOD_HZ_TURBO = 512_000;
  localparam int unsigned TURBO_MUL = 2;
  localparam int unsigned CNT_W = 24;

  // ***********************************************
  // Data rates in samples per second
  // ***********************************************
  localparam int unsigned SPS_0 = 20;
  localparam int unsigned SPS_1 = 45;
  localparam int unsigned SPS_2 = 90;
  localparam int unsigned SPS_3 = 175;
  localparam int unsigned SPS_4 = 330;
  localparam int unsigned SPS_5 = 600;
  localparam int unsigned SPS_6 = 1000;

  // ***********************************************
  // Register indices; byte address is four times
  // ***********************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = ADDR_W - 2;
  localparam logic [9:0] IDX_TIMING = 10'h001;
  localparam logic [9:0] IDX_CHECK_EXC = 10'h002;
  localparam logic [9:0] IDX_DATA = 10'h003;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h004;
  localparam logic [9:0] IDX_IRQ_EN = 10'h005;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h006;
  localparam logic [9:0] IDX_CHECK_WORD = 10'h007;

  // ***********************************************
  // Field positions and reset values
  // ***********************************************
  localparam int unsigned RATE_HI = 7;
  localparam int unsigned RATE_LO = 5;
  localparam int unsigned SPEED_BIT = 4;
  localparam int unsigned CONT_BIT = 3;
  localparam int unsigned REF_HI = 2;
  localparam int unsigned REF_LO = 1;
  localparam int unsigned TEMP_BIT = 0;
  localparam int unsigned READY_BIT = 7;
  localparam int unsigned CNTEN_BIT = 6;
  localparam int unsigned CHK_HI = 5;
  localparam int unsigned CHK_LO = 4;
  localparam int unsigned BURN_BIT = 3;
  localparam int unsigned EXC_HI = 2;
  localparam int unsigned EXC_LO = 0;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [6:0] CHECK_EXC_RST = 7'h00;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SCNT_W = 8;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_OVERRUN = 1;

  // ***********************************************
  // Codes
  // ***********************************************
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_SUPPLY = 2'h2;
  localparam logic [1:0] REF_SUPPLY_ALT = 2'h3;
  localparam logic [1:0] CHK_NONE = 2'h0;
  localparam logic [1:0] CHK_INVERT = 2'h1;
  localparam logic [1:0] CHK_CRC = 2'h2;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  typedef enum logic {ADCCFG_IDLE, ADCCFG_RUN} adccfg_conv_e;

endpackage

// [core/adccfg_divider.sv]
// Programmable period tick generator
`timescale 1ns/1ps
module adccfg_divider #(
  parameter int unsigned CW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [CW-1:0] period,
  // Tick
  output logic tick
);

  logic [CW-1:0] cnt_ff;
  logic tick_ff;

  // ***********************************************
  // Counter
  // ***********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= period - CW'(1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule

// [testbench/tb_top.sv]
// Self-checking testbench for the converter configuration registers
`timescale 1ns/1ps
module tb_top;
  // ***********************************************
  // Signals
  // ***********************************************
  localparam int unsigned CHZ = 2_048_000;
  localparam int unsigned LIMIT = 40_000;
  localparam logic [11:0] A_TIM = {adccfg_pkg::IDX_TIMING, 2'b00};
  localparam logic [11:0] A_CHK = {adccfg_pkg::IDX_CHECK_EXC, 2'b00};
  localparam logic [11:0] A_DAT = {adccfg_pkg::IDX_DATA, 2'b00};
  localparam logic [11:0] A_STA = {adccfg_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_EN = {adccfg_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] A_CLR = {adccfg_pkg::IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] A_CW = {adccfg_pkg::IDX_CHECK_WORD, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic conv_start, turbo_speed, modulator_clk, cont_sel, busy;
  logic [15:0] conv_data;
  logic [2:0] rate_select, exc_one, exc_two;
  logic [1:0] ref_source, integrity_mode;
  logic temp_en, bypass, cnt_en, burn_en, ready_flag, irq, err;
  int failures, checked, cycles;

  adccfg_regs #(.CLK_HZ(CHZ)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_data(conv_data),
    .rate_select(rate_select), .turbo_speed(turbo_speed),
    .modulator_clk(modulator_clk),
    .continuous_conversion_select(cont_sel), .conversion_busy(busy),
    .ref_source(ref_source), .temp_sensor_enable(temp_en),
    .mux_gain_bypass(bypass), .sample_counter_enable(cnt_en),
    .integrity_mode(integrity_mode), .burnout_source_enable(burn_en),
    .excitation_source_one(exc_one), .excitation_source_two(exc_two),
    .result_ready_flag(ready_flag), .irq(irq)
  );

  // ***********************************************
  // Shared tasks
  // ***********************************************
  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (ready_flag !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic pulse_start();
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
  endtask

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = adccfg_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ d[i])
        c = {c[14:0], 1'b0} ^ adccfg_pkg::CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_reset();
    rchk(A_TIM, 32'h0000_0000);
    rchk(A_CHK, 32'h0000_0000);
    check({rate_select, turbo_speed, cont_sel, ref_source, temp_en}, 0);
    check({ready_flag, cnt_en, integrity_mode, burn_en, exc_one}, 0);
    $display("Test reset done");
  endtask

  task automatic t_timing();
    for (int r = 0; r < 4; r++) begin
      wr(A_TIM, {24'h0, 3'h5, 1'b1, 1'b0, r[1:0], 1'b0});
      repeat (2) @(posedge pclk);
      check(ref_source, (r == 3) ? 2 : r);
      check({rate_select, turbo_speed}, {3'h5, 1'b1});
    end
    wr(A_TIM, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    check({temp_en, bypass, ref_source}, 4'hc);
    rchk(A_TIM, 32'h0000_0003);
    for (int t = 0; t < 2; t++) begin
      wr(A_TIM, {27'h0, t[0], 4'h0});
      @(posedge pclk);
      while (modulator_clk === modulator_clk && cycles < LIMIT) begin
        logic m;
        m = modulator_clk;
        @(posedge pclk);
        if (modulator_clk !== m) break;
      end
      err = modulator_clk;
      rd = 0;
      do begin
        @(posedge pclk);
        rd++;
      end while (modulator_clk === err && rd < 100);
      check(rd, CHZ / (2 * (t ? 512_000 : 256_000)));
    end
    $display("Test timing done");
  endtask

  task automatic t_check_reg();
    wr(A_CHK, 32'h0000_00ef);
    rchk(A_CHK, 32'h0000_006f);
    check({cnt_en, integrity_mode, burn_en}, 4'hd);
    for (int e = 0; e < 8; e++) begin
      wr(A_CHK, e);
      @(posedge pclk);
      check({exc_one, exc_two}, {e[2:0], e[2:0]});
      check({cnt_en, burn_en}, 0);
    end
    wr(A_CHK, 32'h0000_0008);
    @(posedge pclk);
    check(burn_en, 1);
    $display("Test check register done");
  endtask

  task automatic t_single();
    int n, p;
    for (int t = 0; t < 2; t++) begin
      wr(A_TIM, {24'h0, 3'h6, t[0], 4'h0});
      wr(A_CHK, 32'h0000_0000);
      conv_data <= 16'h1234 + t;
      pulse_start();
      wait_ready(n);
      p = CHZ / adccfg_pkg::SPS_6 / (t ? 2 : 1);
      check(n >= p - 2 && n <= p + 4, 1);
      rchk(A_CHK, 32'h0000_0080);
      rchk(A_DAT, 32'h1234 + t);
      rchk(A_CHK, 32'h0000_0000);
      check(busy, 0);
    end
    wr(A_TIM, 32'h0000_00e0);
    pulse_start();
    repeat (4) @(posedge pclk);
    check(busy, 0);
    $display("Test single-shot done");
  endtask

  task automatic t_continuous();
    int n;
    logic [7:0] c1;
    conv_data <= 16'h0f5a;
    wr(A_CHK, 32'h0000_0050);
    wr(A_TIM, 32'h0000_00d8);
    wait_ready(n);
    rchk(A_CW, {16'h0, ~16'h0f5a});
    apb(1'b0, A_DAT, 32'h0);
    c1 = rd[23:16];
    wr(A_CHK, 32'h0000_0060);
    conv_data <= 16'h8001;
    wait_ready(n);
    check(n < 1500, 1);
    apb(1'b0, A_DAT, 32'h0);
    check(rd[23:16], c1 + 8'h01);
    rchk(A_CW, {16'h0, crc16(16'h8001)});
    wr(A_TIM, 32'h0000_00d0);
    repeat (1200) @(posedge pclk);
    check(busy, 0);
    $display("Test continuous done");
  endtask

  task automatic t_irq();
    int n;
    apb(1'b0, A_DAT, 32'h0);
    wr(A_CLR, 32'h0000_0003);
    wr(A_EN, 32'h0000_0001);
    check(irq, 0);
    pulse_start();
    wait_ready(n);
    repeat (3) @(posedge pclk);
    check(irq, 1);
    rchk(A_STA, 32'h0000_0001);
    wr(A_EN, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    wr(A_EN, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check(irq, 1);
    wr(A_CLR, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    rchk(A_CLR, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0);
    check(err, 1);
    $display("Test interrupt done");
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, conv_start} = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hf;
    conv_data = 0;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timing();
    t_check_reg();
    t_single();
    t_continuous();
    t_irq();
    final_report();
  end
endmodule
